// ### src/goe_cfg.svh
// Offsets, reset values and widths of the output-enable bank
`ifndef GOE_CFG_SVH
`define GOE_CFG_SVH
`define GOE_ADDR_W          16
`define GOE_PORT_W          8
`define GOE_PORT_A_OE_OFS   16'h30B0
`define GOE_PORT_B_OE_OFS   16'h30B1
`define GOE_PORT_C_OE_OFS   16'h30B2
`define GOE_PORT_D_OE_OFS   16'h30B3
`define GOE_PORT_A_DATA_OFS 16'h3000
`define GOE_PORT_B_DATA_OFS 16'h3001
`define GOE_PORT_C_DATA_OFS 16'h3002
`define GOE_PORT_D_DATA_OFS 16'h3003
`define GOE_OE_RESET        8'h00
`define GOE_DATA_RESET      8'h00
`define GOE_UNMAPPED_READ   32'h00000000
`endif

// ### src/goe_pkg.sv
// Types shared by the output-enable bank
package goe_pkg;
    typedef logic [7:0] goe_byte_t;
    typedef enum logic [1:0] {
        GOE_PORT_A,
        GOE_PORT_B,
        GOE_PORT_C,
        GOE_PORT_D
    } goe_port_t;
endpackage

// ### src/goe_pin_port.sv
// One 8-bit port: enable and data registers plus pin drive and input sync
`timescale 1ns/10ps
`include "goe_cfg.svh"
module goe_pin_port
    import goe_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_sys_in,
    input  wire logic      rst_in,
    // Register writes
    input  wire logic      oe_wr_in,
    input  wire logic      data_wr_in,
    input  wire goe_byte_t wdata_in,
    // Register views
    output goe_byte_t      oe_out,
    output goe_byte_t      data_out,
    output goe_byte_t      pin_level_out,
    // Pins
    input  wire goe_byte_t pin_in,
    output goe_byte_t      pin_out,
    output goe_byte_t      pin_oe_out
);
    goe_byte_t oe;
    goe_byte_t data;
    goe_byte_t sync1;
    goe_byte_t sync2;
    goe_byte_t sync3;
    goe_byte_t level;

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            oe   <= `GOE_OE_RESET;
            data <= `GOE_DATA_RESET;
        end
        else
        begin
            if (oe_wr_in)
                oe <= wdata_in;
            if (data_wr_in)
                data <= wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end
        else
        begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Level updates per bit only once two stages agree
    genvar i;
    generate
        for (i = 0; i < `GOE_PORT_W; i++)
        begin : g_bit
            always_ff @(posedge clk_sys_in or posedge rst_in)
            begin
                if (rst_in)
                    level[i] <= 1'b0;
                else if (sync2[i] == sync3[i])
                    level[i] <= sync3[i];
            end
        end
    endgenerate

    // Data reaches the pin only where enabled; reset enable of 0 drives no pin
    assign pin_out       = data & oe;
    assign pin_oe_out    = oe;
    assign oe_out        = oe;
    assign data_out      = data;
    assign pin_level_out = level;

    a_oe_write_lands : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        oe_wr_in |=> oe_out == $past(wdata_in)) else $error("enable write lost");
    a_oe_holds : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !oe_wr_in |=> $stable(oe_out)) else $error("enable changed without write");
    a_pin_drive_data : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (pin_oe_out & (pin_out ^ data_out)) == 8'h00) else $error("pin not data");
    a_pin_quiet_off : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (pin_out & ~pin_oe_out) == 8'h00) else $error("disabled pin driven");
    a_reset_release : assert property (@(posedge clk_sys_in)
        $fell(rst_in) |-> oe_out == 8'h00 && data_out == 8'h00) else $error("bad reset");
endmodule

// ### src/goe_bank.sv
// Output-enable bank for four 8-bit ports behind an Avalon-MM slave
//
// Overview of operation
// - Port A enable bits read and write; 0 keeps pin undriven, 1 drives.
// - Port B enable register at 30B1h, bit n enables pin n.
// - Port C enable register at 30B2h, bit n enables pin n.
// - Port D enable register at 30B3h, bit n enables pin n.
// - Enabled pins drive the latched data bit of their port.
// - After reset all pins are undriven inputs with pull-ups off.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`include "goe_cfg.svh"
module goe_bank
    import goe_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    // Avalon-MM slave
    input  wire logic [`GOE_ADDR_W-1:0] avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    input  wire logic [3:0]             avs_byteenable_in,
    output logic [31:0]                 avs_readdata_out,
    output logic                        avs_waitrequest_out,
    // Ports A to D pins
    input  wire logic [31:0]            pin_in,
    output logic [31:0]                 pin_out,
    output logic [31:0]                 pin_oe_out,
    // Pull-up enables, always off
    output logic [31:0]                 pullup_en_out
);
    logic [31:0] readdata;
    logic        ack;
    logic [7:0]  oe_q    [4];
    logic [7:0]  data_q  [4];
    logic [7:0]  level_q [4];
    logic [3:0]  oe_hit;
    logic [3:0]  data_hit;
    logic [3:0]  oe_wr;
    logic [3:0]  data_wr;
    logic        any_hit;
    logic        req;
    logic [7:0]  rd_byte;
    logic [31:0] next_readdata;

    // Byte registers sit in the low lane of one word each
    assign req          = avs_read_in | avs_write_in;
    assign oe_hit[0]    = avs_address_in == `GOE_PORT_A_OE_OFS;
    assign oe_hit[1]    = avs_address_in == `GOE_PORT_B_OE_OFS;
    assign oe_hit[2]    = avs_address_in == `GOE_PORT_C_OE_OFS;
    assign oe_hit[3]    = avs_address_in == `GOE_PORT_D_OE_OFS;
    assign data_hit[0]  = avs_address_in == `GOE_PORT_A_DATA_OFS;
    assign data_hit[1]  = avs_address_in == `GOE_PORT_B_DATA_OFS;
    assign data_hit[2]  = avs_address_in == `GOE_PORT_C_DATA_OFS;
    assign data_hit[3]  = avs_address_in == `GOE_PORT_D_DATA_OFS;
    assign any_hit      = |{oe_hit, data_hit};

    // Writes commit on the accepting edge only, so a held request writes once
    genvar p;
    generate
        for (p = 0; p < 4; p++)
        begin : g_port
            assign oe_wr[p]   = avs_write_in & ack & avs_byteenable_in[0] & oe_hit[p];
            assign data_wr[p] = avs_write_in & ack & avs_byteenable_in[0] & data_hit[p];
            goe_pin_port u_port (
                .clk_sys_in    (clk_sys_in),
                .rst_in        (rst_in),
                .oe_wr_in      (oe_wr[p]),
                .data_wr_in    (data_wr[p]),
                .wdata_in      (avs_writedata_in[7:0]),
                .oe_out        (oe_q[p]),
                .data_out      (data_q[p]),
                .pin_level_out (level_q[p]),
                .pin_in        (pin_in[8*p +: 8]),
                .pin_out       (pin_out[8*p +: 8]),
                .pin_oe_out    (pin_oe_out[8*p +: 8])
            );
        end
    endgenerate

    // Data read: output bits give the latch, input bits give the pin level
    assign rd_byte =
        oe_hit[0] ? oe_q[0] :
        oe_hit[1] ? oe_q[1] :
        oe_hit[2] ? oe_q[2] :
        oe_hit[3] ? oe_q[3] :
        data_hit[0] ? ((data_q[0] & oe_q[0]) | (level_q[0] & ~oe_q[0])) :
        data_hit[1] ? ((data_q[1] & oe_q[1]) | (level_q[1] & ~oe_q[1])) :
        data_hit[2] ? ((data_q[2] & oe_q[2]) | (level_q[2] & ~oe_q[2])) :
        data_hit[3] ? ((data_q[3] & oe_q[3]) | (level_q[3] & ~oe_q[3])) :
        8'h00;
    assign next_readdata = any_hit ? {24'h000000, rd_byte} : `GOE_UNMAPPED_READ;

    // One wait cycle lets read data come from a flop
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ack      <= 1'b0;
            readdata <= 32'h00000000;
        end
        else
        begin
            ack <= req & ~ack;
            if (avs_read_in & ~ack)
                readdata <= next_readdata;
        end
    end

    assign avs_waitrequest_out = req & ~ack;
    assign avs_readdata_out    = readdata;
    assign pullup_en_out       = 32'h00000000;

    a_wait_one_cycle : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(req) |-> avs_waitrequest_out ##1 (!avs_waitrequest_out || !req))
        else $error("waitrequest not one cycle");
    a_oe_b_readback : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        avs_read_in && !ack && oe_hit[1] |=> avs_readdata_out == {24'h000000, oe_q[1]})
        else $error("port B enable readback wrong");
    a_oe_c_pins : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        oe_wr[2] |=> pin_oe_out[23:16] == $past(avs_writedata_in[7:0]))
        else $error("port C enable not on pins");
    a_oe_d_pins : assert property (@(posedge clk_sys_in) disable iff (rst_in)
        oe_wr[3] |=> pin_oe_out[31:24] == $past(avs_writedata_in[7:0]))
        else $error("port D enable not on pins");
endmodule

// ### dv/goe_bank_tb_top.sv
// Self-checking bench for the output-enable bank with a byte-level register model
`timescale 1ns/10ps
`include "goe_cfg.svh"
module goe_bank_tb_top
    import goe_pkg::*;
;
    logic        clk_sys_in;
    logic        rst_in;
    logic [15:0] avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [3:0]  avs_byteenable_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe_out;
    logic [31:0] pullup_en_out;
    int          n_errors;
    int          checked;
    int          cycles = 0;
    integer      seed;
    goe_byte_t   m_oe[4];
    goe_byte_t   m_dat[4];
    logic [31:0] rd;

    goe_bank dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .pullup_en_out(pullup_en_out));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    task automatic print_verdict();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard: the whole run needs well under 20000 cycles
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin();
        logic [31:0] oe;
        @(negedge clk_sys_in);
        oe = {m_oe[3], m_oe[2], m_oe[1], m_oe[0]};
        chk_val("pin_oe", oe, pin_oe_out);
        chk_val("pin_out", oe & {m_dat[3], m_dat[2], m_dat[1], m_dat[0]}, pin_out);
        chk_val("pullup", 32'h0, pullup_en_out);
    endtask

    // Request stands until waitrequest is seen low at a rising edge; a hang ends by timeout
    task automatic bus(input logic wr, input logic [15:0] a, input goe_byte_t d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_sys_in);
        avs_address_in    <= a;
        avs_writedata_in  <= {24'($random(seed)), d};
        avs_byteenable_in <= be;
        avs_write_in      <= wr;
        avs_read_in       <= ~wr;
        @(posedge clk_sys_in);
        while (avs_waitrequest_out !== 1'b0)
            @(posedge clk_sys_in);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic reset_and_check(input int n);
        if (rst_in !== 1'b1)
            @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (n) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (int p = 0; p < 4; p++)
        begin
            m_oe[p]  = 8'h00;
            m_dat[p] = 8'h00;
        end
        chk_pin();
        for (int p = 0; p < 4; p++)
        begin
            bus(1'b0, 16'(`GOE_PORT_A_OE_OFS + p), 8'h00, 4'hF, rd);
            chk_val("oe reset", 32'h0, rd);
        end
        $display("test reset done");
    endtask

    initial
    begin
        logic [15:0] a;
        goe_byte_t   v;
        logic [3:0]  be;
        logic        dsel;
        int          p;
        logic [31:0] pins;
        seed = 32'h5E13;
        {n_errors, checked} = '0;
        {avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
        avs_byteenable_in = 4'h0;
        pin_in = 32'h0;
        rst_in = 1'b1;
        reset_and_check(16);
        for (int i = 0; i < 60; i++)
        begin
            p = $unsigned($random(seed)) % 4;
            v = 8'($random(seed));
            be = 4'($random(seed));
            dsel = 1'($random(seed));
            a = 16'((dsel ? `GOE_PORT_A_DATA_OFS : `GOE_PORT_A_OE_OFS) + p);
            pins = $random(seed);
            @(posedge clk_sys_in);
            pin_in <= pins;
            bus(1'b1, a, v, be, rd);
            if (be[0] && dsel)
                m_dat[p] = v;
            else if (be[0])
                m_oe[p] = v;
            chk_pin();
            bus(1'b0, 16'(`GOE_PORT_A_OE_OFS + p), 8'h00, 4'hF, rd);
            chk_val("oe readback", {24'h0, m_oe[p]}, rd);
            // Output bits read the latch, input bits the synchronised pin
            bus(1'b0, 16'(`GOE_PORT_A_DATA_OFS + p), 8'h00, 4'hF, rd);
            chk_val("data readback",
                {24'h0, (m_dat[p] & m_oe[p]) | (pins[8*p +: 8] & ~m_oe[p])}, rd);
        end
        $display("test random access done");
        bus(1'b1, 16'h30B4, 8'hFF, 4'hF, rd);
        bus(1'b0, 16'h30B4, 8'h00, 4'hF, rd);
        chk_val("unmapped read", 32'h0, rd);
        chk_pin();
        $display("test unmapped done");
        reset_and_check(2);
        print_verdict();
    end
endmodule
